// ==== bench/fault_controller.sv ====
/*
 model of the motion controller driving the clear input.
 assumes callers run off the clock edge.
*/
`timescale 1ns/1ps
module fault_controller (
    input wire logic clk_sys,
    output logic     fault_clear_in
);
    initial fault_clear_in = 1'b0;
    // off first, then on
    task clearPulse;
        @(posedge clk_sys) fault_clear_in <= 1'b0;
        @(posedge clk_sys) fault_clear_in <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task setLevel(input logic v);
        @(posedge clk_sys) fault_clear_in <= v;
    endtask
endmodule

// ==== bench/stepper_driver_alarm_unit_properties.sv ====
/*
 checker for the alarm unit, sees only its top ports.
 assumes the bind at the foot hands on the timing parameters.
*/
`timescale 1ns/1ps
module stepper_driver_alarm_unit_properties #(
    parameter int HALF_CYC  = 4,
    parameter int PAUSE_CYC = 10,
    parameter int LONG_CYC  = 20
) (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       overHeat,
    input wire logic       overVoltage,
    input wire logic       overSpeed,
    input wire logic       overCurrent,
    input wire logic       underVoltage,
    input wire logic       brakeError,
    input wire logic       capacitorError,
    input wire logic       storeError,
    input wire logic       peripheralError,
    input wire logic       cpuError,
    input wire logic       fault_clear_in,
    input wire logic       fault_flag_out,
    input wire logic       motorEnable,
    input wire logic       alarmLed,
    input wire logic       alarmActive,
    input wire logic [3:0] alarmCode
);
    logic       sys;
    logic       anyIn;
    logic [3:0] firstCode;
    int         darkCnt;
    assign sys = capacitorError | storeError | peripheralError | cpuError;
    assign anyIn = sys | overHeat | overVoltage | overSpeed | overCurrent | underVoltage | brakeError;
    always_comb begin
        if (sys) firstCode = 4'h9;
        else if (overCurrent) firstCode = 4'h5;
        else if (overVoltage) firstCode = 4'h3;
        else if (overHeat) firstCode = 4'h2;
        else if (overSpeed) firstCode = 4'h4;
        else if (underVoltage) firstCode = 4'h6;
        else firstCode = 4'h7;
    end
    // length of the current dark stretch while alarmed
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) darkCnt <= 0;
        else darkCnt <= (alarmActive && !alarmLed) ? darkCnt + 1 : 0;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_fault_drop: assert property (anyIn |=> !fault_flag_out && !motorEnable && alarmActive)
        else $error("fault input did not drop the flag");
    a_enable_track: assert property (motorEnable == fault_flag_out)
        else $error("motor enable differs from flag");
    a_first_code: assert property (!alarmActive && anyIn |=> alarmCode == $past(firstCode))
        else $error("wrong blink code for cause");
    a_level_hold: assert property (alarmActive && fault_clear_in && $past(fault_clear_in) |=> alarmActive)
        else $error("static clear level cleared alarm");
    a_edge_clears: assert property (alarmActive && !anyIn && fault_clear_in && !$past(fault_clear_in)
        && alarmCode inside {4'h2, 4'h4, 4'h6, 4'h7} |=> !alarmActive && alarmCode == 4'h0)
        else $error("clear edge did not clear");
    a_sys_sticky: assert property (alarmCode == 4'h9 |=> alarmCode == 4'h9)
        else $error("system fault went away");
    a_ocur_sticky: assert property (alarmCode == 4'h5 |=> alarmCode inside {4'h5, 4'h9})
        else $error("overcurrent went away");
    a_ovolt_sticky: assert property (alarmCode == 4'h3 |=> alarmCode inside {4'h3, 4'h5, 4'h9})
        else $error("overvoltage went away");
    a_led_start: assert property ($rose(alarmActive) |-> ##[1:3] alarmLed)
        else $error("led did not start");
    a_led_dark: assert property (!alarmActive [*4] |-> !alarmLed)
        else $error("led lit without alarm");
    a_pause_bound: assert property (darkCnt <= HALF_CYC + LONG_CYC + 4)
        else $error("led dark too long");
endmodule
bind stepper_driver_alarm_unit stepper_driver_alarm_unit_properties #(.HALF_CYC(HALF_CYC), .PAUSE_CYC(PAUSE_CYC),
    .LONG_CYC(LONG_CYC)) u_props (.clk_sys(clk_sys), .rst(rst), .overHeat(overHeat), .overVoltage(overVoltage),
    .overSpeed(overSpeed), .overCurrent(overCurrent), .underVoltage(underVoltage), .brakeError(brakeError),
    .capacitorError(capacitorError), .storeError(storeError), .peripheralError(peripheralError),
    .cpuError(cpuError), .fault_clear_in(fault_clear_in), .fault_flag_out(fault_flag_out),
    .motorEnable(motorEnable), .alarmLed(alarmLed), .alarmActive(alarmActive), .alarmCode(alarmCode));

// ==== bench/stepper_driver_alarm_unit_tb.sv ====
/*
 testbench of the alarm unit with short blink timing.
 assumes the controller model drives the clear input.
*/
`timescale 1ns/1ps
module stepper_driver_alarm_unit_tb;
    localparam int H = 4;
    localparam int L = 20;
    localparam logic [3:0] CODE [10] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'h9, 4'h9, 4'h9};
    logic       clk_sys, rst, clr, flag, motorEnable, alarmLed, alarmActive;
    logic [9:0] flt;
    logic [3:0] alarmCode;
    int         error_cnt, compares, n, g, n2, g2;
    stepper_driver_alarm_unit #(.HALF_CYC(H), .PAUSE_CYC(10), .LONG_CYC(L)) u_stepper_driver_alarm_unit (
        .clk_sys(clk_sys), .rst(rst), .overHeat(flt[0]), .overVoltage(flt[1]), .overSpeed(flt[2]),
        .overCurrent(flt[3]), .underVoltage(flt[4]), .brakeError(flt[5]), .capacitorError(flt[6]),
        .storeError(flt[7]), .peripheralError(flt[8]), .cpuError(flt[9]), .fault_clear_in(clr),
        .fault_flag_out(flag), .motorEnable(motorEnable), .alarmLed(alarmLed), .alarmActive(alarmActive),
        .alarmCode(alarmCode));
    fault_controller u_fault_controller (.clk_sys(clk_sys), .fault_clear_in(clr));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task step;
        @(posedge clk_sys);
        #1;
    endtask
    task powerUp;
        @(posedge clk_sys) rst <= 1'b1;
        flt <= '0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        step();
    endtask
    // one blink group: count of blinks and following dark span
    task grp(output int cnt, output int gap);
        int t;
        t = 0;
        cnt = 0;
        while (!alarmLed && t < 200) begin step(); t++; end
        do begin
            cnt++;
            while (alarmLed && t < 400) begin step(); t++; end
            gap = 0;
            while (!alarmLed && gap < 100) begin step(); gap++; end
        end while (gap <= H + 1 && t < 400);
    endtask
    task t_cause(input int i);
        powerUp();
        flt[i] <= 1'b1;
        @(posedge clk_sys) flt <= '0;
        step();
        chk(flag, 0);
        chk(motorEnable, 0);
        chk(alarmActive, 1);
        chk(alarmCode, CODE[i]);
        if (i == 9) begin
            repeat (30) step();
            chk(alarmLed, 1);
        end else begin
            grp(n, g);
            chk(n, CODE[i]);
            chk(g >= L, i == 8);
            grp(n2, g2);
            chk(n2, n);
            chk(g2, g);
        end
        u_fault_controller.clearPulse();
        chk(flag, 8'(10'h035 >> i) & 8'h01);
        chk(alarmActive, ~(8'(10'h035 >> i)) & 8'h01);
        powerUp();
        chk(flag, 1);
        $display("test cause %0d done", i);
    endtask
    task t_level;
        powerUp();
        u_fault_controller.setLevel(1'b1);
        flt[0] <= 1'b1;
        @(posedge clk_sys) flt <= '0;
        repeat (5) step();
        chk(flag, 0);
        flt[0] <= 1'b1;
        u_fault_controller.clearPulse();
        chk(flag, 0);
        flt <= 10'h003;
        @(posedge clk_sys) flt <= '0;
        u_fault_controller.clearPulse();
        chk(alarmCode, 3);
        powerUp();
        flt[2] <= 1'b1;
        @(posedge clk_sys) flt <= '0;
        u_fault_controller.clearPulse();
        chk(flag, 1);
        repeat (2) step();
        chk(alarmLed, 0);
        $display("test level done");
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        test_done();
    end
    initial begin
        error_cnt = 0;
        compares = 0;
        rst = 1'b1;
        flt = '0;
        for (int i = 0; i < 10; i++) t_cause(i);
        t_level();
        test_done();
    end
endmodule

// ==== rtl/blink_if.sv ====
/*
 * carrier between the fault latch and the led sequencer.
 * assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface blink_if;
    logic       active;
    logic       steady;
    logic       longPause;
    logic [3:0] blinks;

    modport source (output active, output steady, output longPause, output blinks);
    modport sink   (input  active, input  steady, input  longPause, input  blinks);
endinterface

// ==== rtl/clear_edge_detect.sv ====
/*
 * rising edge detector for the fault clear input.
 * assumes the input is already synchronous to clk_sys.
 */
`timescale 1ns/1ps
module clear_edge_detect (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic level,
    output logic      rise
);
    logic levelPrev;

    // start high so a level held through reset is not an edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            levelPrev <= 1'b1;
        end else begin
            levelPrev <= level;
        end
    end

    assign rise = level & ~levelPrev;
endmodule

// ==== rtl/fault_pkg.sv ====
/*
 * shared constants and types for the alarm supervision unit.
 * assumes a 10 MHz system clock; all times are converted to cycles here.
 */
package fault_pkg;

    localparam int  CLK_HZ          = 10_000_000;
    // blink timing; the on and off phases are equal
    localparam int  BLINK_HALF_MS   = 200;
    localparam int  PAUSE_MS        = 1200;
    localparam int  PAUSE_LONG_MS   = 3000;
    localparam int  BLINK_HALF_CYC  = (CLK_HZ / 1000) * BLINK_HALF_MS;
    localparam int  PAUSE_CYC       = (CLK_HZ / 1000) * PAUSE_MS;
    localparam int  PAUSE_LONG_CYC  = (CLK_HZ / 1000) * PAUSE_LONG_MS;

    // blink counts for each cause
    localparam logic [3:0] BLINKS_HEAT  = 4'h2;
    localparam logic [3:0] BLINKS_OVOLT = 4'h3;
    localparam logic [3:0] BLINKS_SPEED = 4'h4;
    localparam logic [3:0] BLINKS_OCUR  = 4'h5;
    localparam logic [3:0] BLINKS_UVOLT = 4'h6;
    localparam logic [3:0] BLINKS_BRAKE = 4'h7;
    localparam logic [3:0] BLINKS_SYS   = 4'h9;

    // fault bit positions in the latched fault vector
    localparam int  F_HEAT    = 0;
    localparam int  F_OVOLT   = 1;
    localparam int  F_SPEED   = 2;
    localparam int  F_OCUR    = 3;
    localparam int  F_UVOLT   = 4;
    localparam int  F_BRAKE   = 5;
    localparam int  F_CAP     = 6;
    localparam int  F_STORE   = 7;
    localparam int  F_PERIPH  = 8;
    localparam int  F_CPU     = 9;
    localparam int  N_FAULTS  = 10;

    localparam logic [N_FAULTS-1:0] CLEARABLE_MASK = 10'h035;
    localparam logic [N_FAULTS-1:0] FAULTS_RESET   = 10'h000;

    typedef enum logic [1:0] {
        LED_IDLE  = 2'b00,
        LED_ON    = 2'b01,
        LED_OFF   = 2'b10,
        LED_PAUSE = 2'b11
    } led_state_t;

endpackage

// ==== rtl/led_sequencer.sv ====
/*
 * drives the alarm led: groups of blinks separated by a pause.
 * assumes the blink request is stable while active.
 */
`timescale 1ns/1ps
module led_sequencer #(
    parameter int HALF_CYC  = fault_pkg::BLINK_HALF_CYC,
    parameter int PAUSE_CYC = fault_pkg::PAUSE_CYC,
    parameter int LONG_CYC  = fault_pkg::PAUSE_LONG_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    blink_if.sink     req,
    output logic      ledOn
);
    fault_pkg::led_state_t state;
    logic [31:0]           timer;
    logic [3:0]            done;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= fault_pkg::LED_IDLE;
            timer <= 32'h0;
            done  <= 4'h0;
            ledOn <= 1'b0;
        end else if (!req.active) begin
            state <= fault_pkg::LED_IDLE;
            timer <= 32'h0;
            done  <= 4'h0;
            ledOn <= 1'b0;
        end else if (req.steady) begin
            ledOn <= 1'b1;
            state <= fault_pkg::LED_IDLE;
        end else begin
            case (state)
                fault_pkg::LED_IDLE: begin
                    state <= fault_pkg::LED_ON;
                    timer <= 32'(HALF_CYC - 1);
                    done  <= 4'h0;
                    ledOn <= 1'b1;
                end
                fault_pkg::LED_ON: begin
                    if (timer == 32'h0) begin
                        state <= fault_pkg::LED_OFF;
                        timer <= 32'(HALF_CYC - 1);
                        done  <= done + 4'h1;
                        ledOn <= 1'b0;
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                fault_pkg::LED_OFF: begin
                    if (timer != 32'h0) begin
                        timer <= timer - 32'h1;
                    end else if (done >= req.blinks) begin
                        state <= fault_pkg::LED_PAUSE;
                        timer <= req.longPause ? 32'(LONG_CYC - 1) : 32'(PAUSE_CYC - 1); // R13
                    end else begin
                        state <= fault_pkg::LED_ON;
                        timer <= 32'(HALF_CYC - 1);
                        ledOn <= 1'b1;
                    end
                end
                fault_pkg::LED_PAUSE: begin
                    if (timer == 32'h0) begin
                        state <= fault_pkg::LED_ON; // R14
                        timer <= 32'(HALF_CYC - 1);
                        done  <= 4'h0;
                        ledOn <= 1'b1;
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                default: begin
                    state <= fault_pkg::LED_IDLE;
                    ledOn <= 1'b0;
                end
            endcase
        end
    end
endmodule

// ==== rtl/stepper_driver_alarm_unit.sv ====
/*
 * alarm supervision of a stepping motor driver: latches fault causes,
 * drops the fault flag, cuts motor current and blinks the cause on the led.
 * assumes fault detect inputs are synchronous level or pulse indications
 * from the sensing circuits, and rst is the power-on reset.
 */
// Overview of operation
// R1: any alarm drops flag, cuts current
// R2: blink led, count identifies cause
// R3: clear input rising edge clears resettable alarms
// R4: controller drives clear off then on
// R5: non-resettable alarms clear only at power-up
// R6: overheat shows two blinks, resettable
// R7: overvoltage shows three blinks, not resettable
// R8: overspeed shows four blinks, resettable
// R9: overcurrent shows five blinks, power-cycle only
// R10: undervoltage shows six blinks, resettable
// R11: brake control error seven blinks, resettable
// R12: system faults nine blinks; cpu steady lit
// R13: peripheral fault uses longer group pause
// R14: groups repeat with fixed configurable pause
`timescale 1ns/1ps
module stepper_driver_alarm_unit #(
    parameter int HALF_CYC  = fault_pkg::BLINK_HALF_CYC,
    parameter int PAUSE_CYC = fault_pkg::PAUSE_CYC,
    parameter int LONG_CYC  = fault_pkg::PAUSE_LONG_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic overHeat,
    input  wire logic overVoltage,
    input  wire logic overSpeed,
    input  wire logic overCurrent,
    input  wire logic underVoltage,
    input  wire logic brakeError,
    input  wire logic capacitorError,
    input  wire logic storeError,
    input  wire logic peripheralError,
    input  wire logic cpuError,
    input  wire logic fault_clear_in,
    output logic      fault_flag_out,
    output logic      motorEnable,
    output logic      alarmLed,
    output logic      alarmActive,
    output logic [3:0] alarmCode
);
    logic [fault_pkg::N_FAULTS-1:0] detect;
    logic [fault_pkg::N_FAULTS-1:0] faults;
    logic [fault_pkg::N_FAULTS-1:0] next_faults;
    logic                           clearRise;
    logic                           ledOn;
    logic [3:0]                     next_code;

    blink_if blink ();

    assign detect = {cpuError, peripheralError, storeError, capacitorError, brakeError,
                     underVoltage, overCurrent, overSpeed, overVoltage, overHeat};

    clear_edge_detect u_clear (
        .clk_sys (clk_sys),
        .rst     (rst),
        .level   (fault_clear_in),
        .rise    (clearRise) // R3
    );

    // clear only resettable bits; a detection in the same cycle wins
    always_comb begin
        next_faults = faults;
        if (clearRise) begin
            next_faults = faults & ~fault_pkg::CLEARABLE_MASK; // R3 R5
        end
        next_faults = next_faults | detect;
    end

    // only the power-on reset clears non-resettable bits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            faults <= fault_pkg::FAULTS_RESET; // R5
        end else begin
            faults <= next_faults;
        end
    end

    // cause with the highest severity picks the blink count
    always_comb begin
        next_code = 4'h0;
        if (next_faults[fault_pkg::F_BRAKE]) begin
            next_code = fault_pkg::BLINKS_BRAKE; // R11
        end
        if (next_faults[fault_pkg::F_UVOLT]) begin
            next_code = fault_pkg::BLINKS_UVOLT; // R10
        end
        if (next_faults[fault_pkg::F_SPEED]) begin
            next_code = fault_pkg::BLINKS_SPEED; // R8
        end
        if (next_faults[fault_pkg::F_HEAT]) begin
            next_code = fault_pkg::BLINKS_HEAT; // R6
        end
        if (next_faults[fault_pkg::F_OVOLT]) begin
            next_code = fault_pkg::BLINKS_OVOLT; // R7
        end
        if (next_faults[fault_pkg::F_OCUR]) begin
            next_code = fault_pkg::BLINKS_OCUR; // R9
        end
        if (|next_faults[fault_pkg::F_CPU:fault_pkg::F_CAP]) begin
            next_code = fault_pkg::BLINKS_SYS; // R12
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            alarmCode <= 4'h0;
        end else begin
            alarmCode <= next_code;
        end
    end

    // flag high means no alarm; motor current follows
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fault_flag_out <= 1'b1;
            motorEnable    <= 1'b1;
            alarmActive    <= 1'b0;
        end else begin
            fault_flag_out <= ~|next_faults; // R1
            motorEnable    <= ~|next_faults; // R1
            alarmActive    <= |next_faults;
        end
    end

    assign blink.active    = |faults; // R2
    assign blink.steady    = faults[fault_pkg::F_CPU]; // R12
    assign blink.longPause = faults[fault_pkg::F_PERIPH]; // R13
    assign blink.blinks    = alarmCode;

    led_sequencer #(
        .HALF_CYC  (HALF_CYC),
        .PAUSE_CYC (PAUSE_CYC),
        .LONG_CYC  (LONG_CYC)
    ) u_led (
        .clk_sys (clk_sys),
        .rst     (rst),
        .req     (blink.sink),
        .ledOn   (ledOn) // R2 R14
    );

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            alarmLed <= 1'b0;
        end else begin
            alarmLed <= ledOn;
        end
    end
endmodule
